// *** eewc_array_model.sv ***
// EEPROM array model facing the write controller
`timescale 1ns/1ps
`default_nettype none
module eewc_array_model
	import eewc_pkg::*;
(
	input  wire logic          core_clk,
	input  wire eewc_arr_req_t arr_req,
	input  wire logic [15:0]   xdata_addr,
	input  wire logic          stall,
	input  wire logic [3:0]    delay,
	output var  logic          arr_done,
	output var  logic [7:0]    arr_rdata
);
	logic [7:0] mem [256];
	logic       pend = 1'b0;
	logic [3:0] cnt = 4'h0;
	initial
	begin
		foreach (mem[i]) mem[i] = 8'h00;
		arr_done = 1'b0;
	end
	// Store each byte, answer after a delay, or never while stalled
	always @(posedge core_clk)
	begin
		arr_done <= 1'b0;
		if (arr_req.we === 1'b1)
		begin
			mem[arr_req.addr] <= arr_req.data;
			pend <= 1'b1;
			cnt <= delay;
		end
		else if (pend && cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (pend && !stall)
		begin
			arr_done <= 1'b1;
			pend <= 1'b0;
		end
	end
	assign arr_rdata = mem[xdata_addr[7:0]];
endmodule : eewc_array_model
`default_nettype wire

// *** eewc_defs.svh ***
// Offsets, field positions, keys and timing figures of the EEPROM write controller
`ifndef EEWC_DEFS_SVH
`define EEWC_DEFS_SVH
`define EEWC_OFS_STAGE0    8'h9A
`define EEWC_OFS_STAGE1    8'h9B
`define EEWC_OFS_STAGE2    8'h9C
`define EEWC_OFS_STAGE3    8'h9D
`define EEWC_OFS_START     8'h9E
`define EEWC_OFS_CTRL      8'hAE
`define EEWC_OFS_KEY       8'hC9
`define EEWC_OFS_AUXILIARY_CONFIG_TWO      8'hF7
`define EEWC_KEY_EEPROM    8'hE2
`define EEWC_BIT_WE        5
`define EEWC_BIT_TO        3
`define EEWC_BIT_LAUNCH    2
`define EEWC_AUXILIARY_CONFIG_TWO_RESET    8'h06
`define EEWC_XDATA_HI      8'hEE
`define EEWC_XDATA_LAST    8'hFE
`define EEWC_CLK_KHZ       200000
`define EEWC_TO1_US        6900
`define EEWC_TO2_US        27000
`define EEWC_TO3_US        55000
`define EEWC_US_TO_CYC(u)  ((u) * (`EEWC_CLK_KHZ / 1000))
`endif

// *** eewc_pkg.sv ***
// Types shared by the EEPROM write controller
package eewc_pkg;
	typedef enum logic [1:0] {
		EEWC_IDLE  = 2'b00,
		EEWC_WRITE = 2'b01,
		EEWC_WAIT  = 2'b11
	} eewc_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} eewc_sfr_req_t;

	typedef struct packed {
		logic        we;
		logic [7:0]  addr;
		logic [7:0]  data;
	} eewc_arr_req_t;

	typedef struct packed {
		eewc_state_t  st;
		logic [7:0]   stage0;
		logic [7:0]   stage1;
		logic [7:0]   stage2;
		logic [7:0]   stage3;
		logic [7:0]   start;
		logic         launch;
		logic [1:0]   len;
		logic [1:0]   idx;
		logic         we_flag;
		logic         to_flag;
		logic [7:0]   auxiliary_config_two;
		logic [23:0]  wdog;
		logic         irq;
		logic [7:0]   sfr_rdata;
		logic [7:0]   xrdata;
		eewc_arr_req_t arr;
	} eewc_regs_t;
endpackage : eewc_pkg

// *** eewc_tb_top.sv ***
// Self-checking bench for the EEPROM write controller
`timescale 1ns/1ps
`default_nettype none
module eewc_tb_top
	import eewc_pkg::*;
;
	localparam int TOC [4] = '{0, 20, 40, 60};
	logic          core_clk, rst_n, xdata_rd, run_mode, isr_enter, stall, arr_done;
	logic          main_wdt_reset_en, eeprom_interrupt_flag, eeprom_busy;
	eewc_sfr_req_t sfr_req;
	eewc_arr_req_t arr_req;
	logic [15:0]   xdata_addr;
	logic [7:0]    sfr_rdata, xdata_rdata, arr_rdata, r, start, st [4];
	logic [3:0]    delay;
	int            failures, cmp_count, n, mem [256];

	eewc_top #(.TO1_CYC(20), .TO2_CYC(40), .TO3_CYC(60)) eewc_top_inst (.core_clk(core_clk),
		.rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .xdata_rd(xdata_rd),
		.xdata_addr(xdata_addr), .xdata_rdata(xdata_rdata), .run_mode(run_mode),
		.main_wdt_reset_en(main_wdt_reset_en), .isr_enter(isr_enter),
		.eeprom_interrupt_flag(eeprom_interrupt_flag), .eeprom_busy(eeprom_busy),
		.arr_req(arr_req), .arr_done(arr_done), .arr_rdata(arr_rdata));
	eewc_array_model eewc_array_model_inst (.core_clk(core_clk), .arr_req(arr_req),
		.xdata_addr(xdata_addr), .stall(stall), .delay(delay), .arr_done(arr_done),
		.arr_rdata(arr_rdata));

	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask : chk
	task sfr_acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge core_clk);
		sfr_req = '0;
		r = sfr_rdata;
	endtask : sfr_acc
	task pulse_isr();
		@(negedge core_clk);
		isr_enter = 1'b1;
		@(negedge core_clk);
		isr_enter = 1'b0;
	endtask : pulse_isr
	task wait_idle(output int c);
		c = 2;
		repeat (2) @(negedge core_clk);
		while (eeprom_busy !== 1'b0 && c < 400)
		begin
			@(negedge core_clk);
			c++;
		end
		if (c >= 400)
			failures++;
	endtask : wait_idle
	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial
	begin
		#60us;
		failures++;
		tally_and_finish();
	end
	initial
	begin
		{rst_n, xdata_rd, run_mode, isr_enter, stall, delay} = '0;
		sfr_req = '0;
		xdata_addr = 16'hEE00;
		foreach (mem[i]) mem[i] = 0;
		void'($urandom(79));
		repeat (4) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		sfr_acc(1'b0, 8'hF7, 8'h00);
		chk(r, 8'h06);
		sfr_acc(1'b1, 8'hC9, 8'hE2);
		sfr_acc(1'b0, 8'hC9, 8'h00);
		chk(r[5], 1'b1);
		sfr_acc(1'b1, 8'hC9, 8'h47);
		sfr_acc(1'b0, 8'hC9, 8'h00);
		chk(r[5], 1'b0);
		$display("key test done");
		for (int k = 0; k < 8; k++)
		begin
			run_mode = k[2];
			sfr_acc(1'b1, 8'hF7, {k[1:0], 6'h06});
			repeat (2) @(negedge core_clk);
			chk(main_wdt_reset_en, k[1] & (k[0] | k[2]));
		end
		$display("watchdog mode test done");
		sfr_acc(1'b1, 8'hC9, 8'hE2);
		for (int len = 0; len < 4; len++)
		begin
			delay = 4'(len * 2);
			start = 8'($urandom_range(0, 250));
			for (int i = 0; i < 4; i++)
			begin
				st[i] = 8'($urandom);
				sfr_acc(1'b1, 8'h9A + 8'(i), st[i]);
			end
			sfr_acc(1'b1, 8'h9E, start);
			sfr_acc(1'b1, 8'hAE, {6'h01, 2'(len)});
			wait_idle(n);
			chk(eeprom_interrupt_flag, 1'b1);
			sfr_acc(1'b0, 8'hC9, 8'h00);
			chk({r[5], r[3]}, 2'b10);
			pulse_isr();
			chk(eeprom_interrupt_flag, 1'b0);
			for (int i = 0; i <= len; i++) mem[8'(start + 8'(i))] = st[i];
			for (int i = 0; i < 5; i++)
			begin
				@(negedge core_clk);
				xdata_addr = {8'hEE, 8'(start + 8'(i))};
				xdata_rd = 1'b1;
				repeat (2) @(negedge core_clk);
				xdata_rd = 1'b0;
				chk(xdata_rdata, 16'(mem[xdata_addr[7:0]]));
			end
		end
		$display("hardware write test done");
		stall = 1'b1;
		sfr_acc(1'b1, 8'hF7, 8'h00);
		sfr_acc(1'b1, 8'hAE, 8'h04);
		repeat (100) @(negedge core_clk);
		chk(eeprom_busy, 1'b1);
		stall = 1'b0;
		wait_idle(n);
		chk(eeprom_interrupt_flag, 1'b1);
		pulse_isr();
		stall = 1'b1;
		for (int s = 1; s < 4; s++)
		begin
			sfr_acc(1'b1, 8'hC9, 8'hE2);
			sfr_acc(1'b1, 8'hF7, {5'h00, 2'(s), 1'b0});
			sfr_acc(1'b1, 8'hAE, 8'h07);
			wait_idle(n);
			chk(n >= TOC[s] - 4 && n <= TOC[s] + 6, 1'b1);
			sfr_acc(1'b0, 8'hC9, 8'h00);
			chk(r[3], 1'b1);
			chk(eeprom_interrupt_flag, 1'b1);
			pulse_isr();
			sfr_acc(1'b1, 8'hC9, 8'h00);
			sfr_acc(1'b0, 8'hC9, 8'h00);
			chk(r[3], 1'b0);
		end
		$display("time-out test done");
		tally_and_finish();
	end
endmodule : eewc_tb_top
`default_nettype wire

// *** eewc_top.sv ***
// EEPROM write controller: key, write watchdog, hardware multi-byte writer, read decode
`timescale 1ns/1ps
`default_nettype none
`include "eewc_defs.svh"

module eewc_top
	import eewc_pkg::*;
#(
	parameter int unsigned TO1_CYC   = `EEWC_US_TO_CYC(`EEWC_TO1_US),
	parameter int unsigned TO2_CYC   = `EEWC_US_TO_CYC(`EEWC_TO2_US),
	parameter int unsigned TO3_CYC   = `EEWC_US_TO_CYC(`EEWC_TO3_US)
)(
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire eewc_sfr_req_t sfr_req,
	output var  logic [7:0]    sfr_rdata,
	input  wire logic          xdata_rd,
	input  wire logic [15:0]   xdata_addr,
	output var  logic [7:0]    xdata_rdata,
	input  wire logic          run_mode,
	output var  logic          main_wdt_reset_en,
	input  wire logic          isr_enter,
	output var  logic          eeprom_interrupt_flag,
	output var  logic          eeprom_busy,
	output var  eewc_arr_req_t arr_req,
	input  wire logic          arr_done,
	input  wire logic [7:0]    arr_rdata
);

	logic        rst_meta_n;
	logic        rst_sync_n;
	eewc_regs_t  r;
	eewc_regs_t  next_r;
	logic        wdt_en_q;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	function automatic logic [23:0] wdog_limit(input logic [1:0] sel);
		case (sel)
			2'b01:   wdog_limit = 24'(TO1_CYC);
			2'b10:   wdog_limit = 24'(TO2_CYC);
			default: wdog_limit = 24'(TO3_CYC);
		endcase
	endfunction : wdog_limit

	function automatic logic [7:0] staged(input eewc_regs_t s, input logic [1:0] i);
		case (i)
			2'b00:   staged = s.stage0;
			2'b01:   staged = s.stage1;
			2'b10:   staged = s.stage2;
			default: staged = s.stage3;
		endcase
	endfunction : staged

	function automatic logic ee_hit(input logic [15:0] a);
		ee_hit = (a[15:8] == `EEWC_XDATA_HI) && (a[7:0] <= `EEWC_XDATA_LAST);
	endfunction : ee_hit

	always_comb
	begin
		logic wd_on;
		logic expire;
		logic finish;
		wd_on  = (r.auxiliary_config_two[2:1] != 2'b00);
		expire = 1'b0;
		finish = 1'b0;
		next_r = r;
		next_r.arr.we = 1'b0;
		if (sfr_req.wr)
		begin
			case (sfr_req.addr)
				`EEWC_OFS_STAGE0: next_r.stage0 = sfr_req.wdata;
				`EEWC_OFS_STAGE1: next_r.stage1 = sfr_req.wdata;
				`EEWC_OFS_STAGE2: next_r.stage2 = sfr_req.wdata;
				`EEWC_OFS_STAGE3: next_r.stage3 = sfr_req.wdata;
				`EEWC_OFS_START:  next_r.start  = sfr_req.wdata;
				`EEWC_OFS_KEY:    next_r.we_flag = (sfr_req.wdata == `EEWC_KEY_EEPROM);
				`EEWC_OFS_AUXILIARY_CONFIG_TWO:   next_r.auxiliary_config_two = sfr_req.wdata;
				`EEWC_OFS_CTRL:
				begin
					next_r.len = sfr_req.wdata[1:0];
					if (sfr_req.wdata[`EEWC_BIT_LAUNCH] && r.st == EEWC_IDLE)
					begin
						next_r.launch = 1'b1;
						next_r.idx    = 2'b00;
						next_r.wdog   = 24'h000000;
						next_r.st     = EEWC_WRITE;
					end
				end
				default: ;
			endcase
		end
		case (r.st)
			EEWC_WRITE:
			begin
				next_r.arr.we   = 1'b1;
				next_r.arr.addr = r.start + {6'h00, r.idx};
				next_r.arr.data = staged(r, r.idx);
				next_r.st       = EEWC_WAIT;
			end
			EEWC_WAIT:
			begin
				if (arr_done)
				begin
					if (r.idx == r.len)
						finish = 1'b1;
					else
					begin
						next_r.idx = r.idx + 2'b01;
						next_r.st  = EEWC_WRITE;
					end
				end
			end
			default: ;
		endcase
		if (r.st != EEWC_IDLE && wd_on)
		begin
			if (r.wdog >= wdog_limit(r.auxiliary_config_two[2:1]) - 24'h000001)
				expire = 1'b1;
			else
				next_r.wdog = r.wdog + 24'h000001;
		end
		if (finish || expire)
		begin
			next_r.st     = EEWC_IDLE;
			next_r.launch = 1'b0;
			next_r.arr.we = 1'b0;
		end
		if (expire)
			next_r.to_flag = 1'b1;
		if (!next_r.we_flag)
			next_r.to_flag = 1'b0;
		if (isr_enter)
			next_r.irq = 1'b0;
		if (finish || expire)
			next_r.irq = 1'b1;
		next_r.sfr_rdata = 8'h00;
		if (sfr_req.rd)
		begin
			case (sfr_req.addr)
				`EEWC_OFS_KEY:
				begin
					next_r.sfr_rdata[`EEWC_BIT_WE] = r.we_flag;
					next_r.sfr_rdata[`EEWC_BIT_TO] = r.to_flag;
				end
				`EEWC_OFS_AUXILIARY_CONFIG_TWO: next_r.sfr_rdata = r.auxiliary_config_two;
				default: next_r.sfr_rdata = 8'h00;
			endcase
		end
		next_r.xrdata = r.xrdata;
		if (xdata_rd && ee_hit(xdata_addr))
			next_r.xrdata = arr_rdata;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			r          <= '0;
			r.st       <= EEWC_IDLE;
			r.auxiliary_config_two     <= `EEWC_AUXILIARY_CONFIG_TWO_RESET;
			wdt_en_q   <= 1'b0;
		end
		else
		begin
			r        <= next_r;
			wdt_en_q <= r.auxiliary_config_two[7] && (r.auxiliary_config_two[6] || run_mode);
		end
	end

	// Outputs straight from flops; busy never stalls the CPU
	assign sfr_rdata             = r.sfr_rdata;
	assign xdata_rdata           = r.xrdata;
	assign main_wdt_reset_en     = wdt_en_q;
	assign eeprom_interrupt_flag = r.irq;
	assign eeprom_busy           = r.launch;
	assign arr_req               = r.arr;

	a_key_sets_we: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		sfr_req.wr && sfr_req.addr == `EEWC_OFS_KEY
		|=> r.we_flag == ($past(sfr_req.wdata) == `EEWC_KEY_EEPROM))
		else $error("write enable does not follow key");
	a_to_needs_we: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		!r.we_flag |-> !r.to_flag)
		else $error("time-out flag set without write enable");
	a_launch_write: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		r.st == EEWC_IDLE && sfr_req.wr && sfr_req.addr == `EEWC_OFS_CTRL
		&& sfr_req.wdata[`EEWC_BIT_LAUNCH] |=> ##1 arr_req.we)
		else $error("launch did not start array write");
	a_addr_consec: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		arr_req.we |-> arr_req.addr == r.start + {6'h00, r.idx})
		else $error("array address not consecutive");
	a_done_irq: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		$fell(eeprom_busy) |-> r.irq)
		else $error("completion without interrupt flag");
	a_isr_clear: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		isr_enter |=> !r.irq || $fell(r.launch))
		else $error("interrupt flag not cleared on service entry");
	a_wd_off_no_to: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		r.auxiliary_config_two[2:1] == 2'b00 && !r.to_flag |=> !r.to_flag)
		else $error("time-out with watchdog disabled");
	a_expire_idle: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		$rose(r.to_flag) |-> r.st == EEWC_IDLE && !r.launch)
		else $error("expiry left write running");
	a_main_wdt: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		!$past(r.auxiliary_config_two[7]) |-> !main_wdt_reset_en)
		else $error("main watchdog reset enabled while off");

	// Steps of a hardware write
	sequence s_launch_req;
		r.st == EEWC_IDLE && sfr_req.wr && sfr_req.addr == `EEWC_OFS_CTRL
		&& sfr_req.wdata[`EEWC_BIT_LAUNCH];
	endsequence
	sequence s_byte_done;
		r.st == EEWC_WAIT && arr_done;
	endsequence

	// Launch and byte sequencing
	a_launch_busy: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		s_launch_req |=> eeprom_busy && r.st == EEWC_WRITE)
		else $error("launch did not raise busy");
	a_first_byte: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		s_launch_req ##1 1'b1 |=> arr_req.we && arr_req.data == $past(r.stage0)
		&& arr_req.addr == $past(r.start))
		else $error("first byte not from first stage at start address");
	a_stage_one: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		arr_req.we && r.idx == 2'b01 |-> arr_req.data == $past(r.stage1))
		else $error("second byte not from second stage");
	a_stage_two: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		arr_req.we && r.idx == 2'b10 |-> arr_req.data == $past(r.stage2))
		else $error("third byte not from third stage");
	a_stage_three: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		arr_req.we && r.idx == 2'b11 |-> arr_req.data == $past(r.stage3))
		else $error("fourth byte not from fourth stage");
	a_we_pulse: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		arr_req.we |=> !arr_req.we)
		else $error("array write strobe longer than one cycle");
	a_byte_count: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		s_byte_done && r.idx == r.len |=> !eeprom_busy)
		else $error("write did not end after last byte");
	a_next_byte: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		s_byte_done && r.idx != r.len
		|=> r.st == EEWC_WRITE && r.idx == $past(r.idx) + 2'b01 || !eeprom_busy)
		else $error("next byte not started");
	a_busy_state: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		eeprom_busy == (r.st != EEWC_IDLE))
		else $error("busy flag disagrees with write state");

	// Write watchdog
	a_to_on_expire: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		eeprom_busy && r.auxiliary_config_two[2:1] != 2'b00 && r.we_flag
		&& r.wdog >= wdog_limit(r.auxiliary_config_two[2:1]) - 24'h000001
		&& !(sfr_req.wr && sfr_req.addr == `EEWC_OFS_KEY)
		|=> r.to_flag && !eeprom_busy && eeprom_interrupt_flag)
		else $error("expiry did not flag and abort");
	a_wdog_reset: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		s_launch_req |=> r.wdog == 24'h000000)
		else $error("watchdog count not cleared at launch");
	a_wdog_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		eeprom_busy && r.auxiliary_config_two[2:1] == 2'b00 |=> r.wdog == $past(r.wdog))
		else $error("watchdog counts while disabled");
	a_wdog_count: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		eeprom_busy && r.auxiliary_config_two[2:1] != 2'b00
		&& r.wdog < wdog_limit(r.auxiliary_config_two[2:1]) - 24'h000001
		|=> r.wdog == $past(r.wdog) + 24'h000001)
		else $error("watchdog count did not advance");
	a_expire_needs_wd: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		$rose(r.to_flag) |-> $past(r.auxiliary_config_two[2:1]) != 2'b00)
		else $error("time-out raised with watchdog off");

	// Register access
	a_key_read: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		sfr_req.rd && sfr_req.addr == `EEWC_OFS_KEY |=> sfr_rdata[`EEWC_BIT_WE] == $past(r.we_flag)
		&& sfr_rdata[`EEWC_BIT_TO] == $past(r.to_flag))
		else $error("key register read-back wrong");
	a_key_ro_to: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		!eeprom_busy && !r.to_flag |=> !r.to_flag)
		else $error("time-out flag set outside a write");
	a_wo_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		sfr_req.rd && sfr_req.addr inside {`EEWC_OFS_STAGE0, `EEWC_OFS_STAGE1,
		`EEWC_OFS_STAGE2, `EEWC_OFS_STAGE3, `EEWC_OFS_START, `EEWC_OFS_CTRL}
		|=> sfr_rdata == 8'h00)
		else $error("write-only register read back nonzero");
	a_rd_idle_zero: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		!sfr_req.rd |=> sfr_rdata == 8'h00)
		else $error("read data present without read");
	a_stage0_write: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		sfr_req.wr && sfr_req.addr == `EEWC_OFS_STAGE0 |=> r.stage0 == $past(sfr_req.wdata))
		else $error("first stage not written");
	a_start_write: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		sfr_req.wr && sfr_req.addr == `EEWC_OFS_START |=> r.start == $past(sfr_req.wdata))
		else $error("start address not written");
	a_len_write: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		sfr_req.wr && sfr_req.addr == `EEWC_OFS_CTRL |=> r.len == $past(sfr_req.wdata[1:0]))
		else $error("length field not written");

	// External reads, main watchdog and interrupt flag
	a_xdata_hit: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		xdata_rd && ee_hit(xdata_addr) |=> xdata_rdata == $past(arr_rdata))
		else $error("EEPROM read data not captured");
	a_xdata_miss: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		!(xdata_rd && ee_hit(xdata_addr)) |=> $stable(xdata_rdata))
		else $error("read data changed without EEPROM read");
	a_wdt_always: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		$past(r.auxiliary_config_two[7:6]) == 2'b11 |-> main_wdt_reset_en)
		else $error("main watchdog reset not always enabled");
	a_wdt_run: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		$past(r.auxiliary_config_two[7:6]) == 2'b10 |-> main_wdt_reset_en == $past(run_mode))
		else $error("main watchdog reset not tied to run mode");
	a_irq_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		eeprom_interrupt_flag && !isr_enter |=> eeprom_interrupt_flag)
		else $error("interrupt flag dropped without service entry");
	a_irq_only_done: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		$rose(eeprom_interrupt_flag) |-> $fell(eeprom_busy))
		else $error("interrupt flag raised without write end");

endmodule : eewc_top
`default_nettype wire
